// ===== design/ums_pkg.sv
/*
 * ums_pkg: constants shared by the usart master spi transfer block.
 * assumes a single 100 MHz system clock and plain control/status ports.
 */
// Operation
// - mode select field 2'b11 enables master spi operation.
// - transfer clock is system clock over 2*(baud divisor+1), divisor 0-4095.
// - shift and sample on opposite clock edges; polarity and phase pick mode.
// - eight-bit frames; data order bit picks msb or lsb first for both.
// - transmitter enable required; serial out pin then carries transmit data.
// - receiver enable optional; serial in pin then used as receive data.
// - transfer clock pin drives shift clock whenever a transfer runs.
// - data register write starts full duplex transfer; nothing else does.
// - transmit buffer moves to shift register once shifter can start frame.
// - on receive overflow newest byte is dropped, oldest data kept.
// - receive complete, transmit complete, data empty flags act as usual.
// - framing error, overrun and parity flags always read zero.
// - disabling transmitter or receiver behaves as in normal usart.
// - polarity, phase and order bits behave like spi port controls.
// - transmitter double buffered; receiver holds one extra buffered byte.
// - no write collision status is provided.
// - master only; no slave select pin.
package ums_pkg;
    localparam int          UMS_DATA_W    = 8;
    localparam int          UMS_BAUD_W    = 12;
    localparam int          UMS_BITS      = 8;
    localparam int          UMS_RX_DEPTH  = 2;
    localparam logic [1:0]  UMS_MODE_MSPI = 2'h3;
    localparam logic [11:0] UMS_BAUD_RST  = 12'h000;
    localparam logic [7:0]  UMS_DATA_RST  = 8'h00;
    localparam logic [3:0]  UMS_BIT_LAST  = 4'h7;
    typedef enum logic [1:0] {UMS_IDLE, UMS_LEAD, UMS_TRAIL} ums_state_t;
endpackage

// ===== design/ums_baud_gen.sv
/*
 * ums_baud_gen: half-period tick generator for the transfer clock.
 * assumes divisor is steady during a frame; restarts while run_i is low.
 */
module ums_baud_gen
    import ums_pkg::*;
#(
    parameter int BAUD_W = UMS_BAUD_W
) (
    input  wire logic              clk_sys_i, // system clock
    input  wire logic              arst_n_i,  // async reset, active low
    input  wire logic              run_i,     // frame in progress
    input  wire logic [BAUD_W-1:0] div_i,     // baud divisor
    output logic                   tick_o     // one half period elapsed
);
    logic [BAUD_W-1:0] cnt_r;

    // half period is div+1 system clocks, full period 2*(div+1)
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_r <= '0;
        end else if (!run_i || cnt_r == div_i) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    assign tick_o = run_i && (cnt_r == div_i);

    tick_period_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        tick_o && run_i |=> !tick_o || div_i == '0)
        else $error("baud tick came too early");
endmodule

// ===== design/ums_rx_buf.sv
/*
 * ums_rx_buf: small receive buffer with registered read data.
 * assumes one push per completed frame; a push when full is dropped unless a pop comes in the same cycle.
 */
module ums_rx_buf
    import ums_pkg::*;
#(
    parameter int W     = UMS_DATA_W,
    parameter int DEPTH = UMS_RX_DEPTH
) (
    input  wire logic         clk_sys_i, // system clock
    input  wire logic         arst_n_i,  // async reset, active low
    input  wire logic         flush_i,   // receiver disabled
    input  wire logic         push_i,    // received byte valid
    input  wire logic [W-1:0] push_d_i,  // received byte
    input  wire logic         pop_i,     // software read of data register
    output logic [W-1:0]      rd_d_o,    // oldest byte, registered
    output logic              avail_o,   // unread data present
    output logic              full_o     // no room left
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0]  mem_r [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0]   cnt_r;
    logic          do_push;
    logic          do_pop;

    assign avail_o = (cnt_r != '0);
    assign full_o  = (cnt_r == (AW+1)'(DEPTH));
    assign do_pop  = pop_i && avail_o;
    // newest byte is lost on overflow, buffer kept intact
    assign do_push = push_i && (!full_o || do_pop);

    // storage
    always_ff @(posedge clk_sys_i) begin
        if (do_push) begin
            mem_r[wp_r] <= push_d_i;
        end
    end

    // pointers and fill count
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else if (flush_i) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (do_push) begin
                wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
            end
            if (do_pop) begin
                rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
            end
            cnt_r <= cnt_r + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end

    // registered view of the oldest entry
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rd_d_o <= '0;
        end else begin
            rd_d_o <= mem_r[rp_r];
        end
    end

    keep_oldest_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        full_o && push_i && !pop_i && !flush_i |=> full_o && $stable(rp_r))
        else $error("overflow disturbed buffered data");
endmodule

// ===== design/ums_mspi.sv
/*
 * ums_mspi: usart master spi transfer engine with double buffered
 * transmitter, two-deep receiver, baud generator and pin overrides.
 * assumes control inputs are synchronous to clk_sys_i, data writes and
 * reads are one-cycle strobes, and slave select comes from other logic.
 */
module ums_mspi
    import ums_pkg::*;
#(
    parameter int BAUD_W   = UMS_BAUD_W,
    parameter int RX_DEPTH = UMS_RX_DEPTH
) (
    input  wire logic              clk_sys_i,    // system clock
    input  wire logic              arst_n_i,     // async reset, active low
    input  wire logic [1:0]        mode_sel_i,   // usart mode select field
    input  wire logic              tx_en_i,      // transmitter enable bit
    input  wire logic              rx_en_i,      // receiver enable bit
    input  wire logic              cpol_i,       // clock polarity bit
    input  wire logic              cpha_i,       // clock phase bit
    input  wire logic              lsb_first_i,  // data order bit
    input  wire logic [BAUD_W-1:0] baud_div_i,   // baud divisor
    input  wire logic              data_wr_i,    // data register write strobe
    input  wire logic [7:0]        data_wdata_i, // data to transmit
    input  wire logic              data_rd_i,    // data register read strobe
    input  wire logic              txc_clr_i,    // clear transmit complete
    output logic [7:0]             data_rdata_o, // oldest received byte
    output logic                   rxc_o,        // receive complete flag
    output logic                   txc_o,        // transmit complete flag
    output logic                   udre_o,       // data register empty flag
    output logic                   fe_o,         // framing error flag
    output logic                   dor_o,        // data overrun flag
    output logic                   pe_o,         // parity error flag
    output logic                   busy_o,       // frame shifting
    output logic                   sck_o,        // transfer clock pin out
    output logic                   sck_oe_o,     // transfer clock pin enable
    output logic                   mosi_o,       // serial out pin value
    output logic                   mosi_oe_o,    // serial out pin override
    input  wire logic              miso_i,       // serial in pin
    output logic                   miso_ovr_o    // serial in pin override
);
    ums_state_t  st_r;
    logic        mspi_on;
    logic        tx_on;
    logic        tick;
    logic [7:0]  txb_r;
    logic        txb_full_r;
    logic [7:0]  sh_r;
    logic [3:0]  bit_r;
    logic        samp_r;
    logic        sck_r;
    logic        rx_push;
    logic [7:0]  rx_byte;
    logic        last_bit;
    logic        load;
    logic        rx_full;

    // bit order picker, used for shifting out and capturing in
    function automatic logic out_bit(input logic [7:0] d, input logic lsb);
        out_bit = lsb ? d[0] : d[7];
    endfunction

    function automatic logic [7:0] shift_in(input logic [7:0] d,
                                            input logic       lsb,
                                            input logic       b);
        shift_in = lsb ? {b, d[7:1]} : {d[6:0], b};
    endfunction

    // master spi operation only when both mode bits set
    assign mspi_on = (mode_sel_i == UMS_MODE_MSPI);
    // transmitter enable is required for any transfer
    assign tx_on   = mspi_on && tx_en_i;
    assign last_bit = (bit_r == UMS_BIT_LAST);
    // buffered byte enters shifter once idle
    assign load    = tx_on && (st_r == UMS_IDLE) && txb_full_r;

    ums_baud_gen #(
        .BAUD_W (BAUD_W)
    ) u_baud (
        .clk_sys_i (clk_sys_i),
        .arst_n_i  (arst_n_i),
        .run_i     (st_r != UMS_IDLE),
        .div_i     (baud_div_i),
        .tick_o    (tick)
    );

    // transmit buffer, second stage of the double buffer
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            txb_r      <= UMS_DATA_RST;
            txb_full_r <= 1'b0;
        end else if (!tx_on) begin
            txb_full_r <= 1'b0; // disabling drops queued data
        end else if (data_wr_i && (!txb_full_r || load)) begin
            txb_r      <= data_wdata_i; // write starts a transfer
            txb_full_r <= 1'b1;
        end else if (load) begin
            txb_full_r <= 1'b0;
        end
    end
    // a write into a full buffer is ignored unless the buffer loads that cycle, no collision flag

    // frame sequencer: leading edge then trailing edge per bit
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_r  <= UMS_IDLE;
            bit_r <= '0;
        end else if (!tx_on) begin
            st_r  <= UMS_IDLE; // transmitter off aborts frame
            bit_r <= '0;
        end else begin
            unique case (st_r)
                UMS_IDLE: begin
                    if (load) begin
                        st_r  <= UMS_LEAD;
                        bit_r <= '0;
                    end
                end
                UMS_LEAD: begin
                    if (tick) begin
                        st_r <= UMS_TRAIL;
                    end
                end
                UMS_TRAIL: begin
                    if (tick) begin
                        if (last_bit && !txb_full_r) begin
                            st_r <= UMS_IDLE;
                        end else if (last_bit) begin
                            st_r <= UMS_IDLE; // next frame loads at once
                        end else begin
                            st_r  <= UMS_LEAD;
                            bit_r <= bit_r + 4'h1;
                        end
                    end
                end
            endcase
        end
    end

    // transfer clock level: toggles on each half period tick
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sck_r <= 1'b0;
        end else if (st_r == UMS_IDLE) begin
            sck_r <= 1'b0;
        end else if (tick) begin
            sck_r <= ~sck_r;
        end
    end
    assign sck_o    = sck_r ^ cpol_i; // idle level follows polarity
    assign sck_oe_o = mspi_on; // pin always driven as master

    // shift register: sample and setup on opposite edges
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sh_r   <= UMS_DATA_RST;
            samp_r <= 1'b0;
        end else if (load) begin
            sh_r <= txb_r;
        end else if (tick) begin
            // sample edge: leading if phase 0, trailing if phase 1
            if ((st_r == UMS_LEAD) != cpha_i) begin
                samp_r <= miso_i;
            end
            // setup edge shifts the captured bit in
            if ((st_r == UMS_LEAD) == cpha_i && !(cpha_i && bit_r == '0)) begin
                sh_r <= shift_in(sh_r, lsb_first_i, samp_r);
            end
        end
    end

    // byte complete: take final sample into the received byte
    assign rx_push = tick && (st_r == UMS_TRAIL) && last_bit
                     && mspi_on && rx_en_i;
    assign rx_byte = cpha_i ? shift_in(sh_r, lsb_first_i, miso_i)
                            : shift_in(sh_r, lsb_first_i, samp_r);

    // receiver: optional, discards newest on overflow
    ums_rx_buf #(
        .W     (UMS_DATA_W),
        .DEPTH (RX_DEPTH)
    ) u_rxb (
        .clk_sys_i (clk_sys_i),
        .arst_n_i  (arst_n_i),
        .flush_i   (!(mspi_on && rx_en_i)),
        .push_i    (rx_push),
        .push_d_i  (rx_byte),
        .pop_i     (data_rd_i),
        .rd_d_o    (data_rdata_o),
        .avail_o   (rxc_o),
        .full_o    (rx_full)
    );

    // transmit complete: set at frame end with nothing queued
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            txc_o <= 1'b0;
        end else if (tick && st_r == UMS_TRAIL && last_bit && !txb_full_r) begin
            txc_o <= 1'b1; // set wins over clear
        end else if (txc_clr_i) begin
            txc_o <= 1'b0;
        end
    end

    // serial out data; first bit at load, later bits on the setup edge so
    // the line never moves on a sample edge, even at divisor zero
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mosi_o <= 1'b1;
        end else if (!tx_on) begin
            mosi_o <= 1'b1;
        end else if (load) begin
            mosi_o <= out_bit(txb_r, lsb_first_i);
        end else if (st_r == UMS_IDLE) begin
            mosi_o <= 1'b1;
        end else if (tick && (st_r == UMS_LEAD) == cpha_i
                     && !(cpha_i && bit_r == '0)) begin
            mosi_o <= out_bit(shift_in(sh_r, lsb_first_i, samp_r),
                              lsb_first_i);
        end
    end

    assign udre_o     = tx_on && !txb_full_r;
    assign mosi_oe_o  = tx_on;
    assign miso_ovr_o = mspi_on && rx_en_i;
    assign busy_o     = (st_r != UMS_IDLE);
    // error flags unused in this mode
    assign fe_o  = 1'b0;
    assign dor_o = 1'b0;
    assign pe_o  = 1'b0;

    sequence frame_end_s;
        tick && st_r == UMS_TRAIL && last_bit && !txb_full_r;
    endsequence

    no_start_off_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        !tx_on |=> st_r == UMS_IDLE)
        else $error("frame ran without transmitter");
    load_start_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        load |=> st_r == UMS_LEAD && bit_r == '0)
        else $error("loaded byte did not start a frame");
    txc_set_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        frame_end_s |=> txc_o && st_r == UMS_IDLE)
        else $error("transmit complete missing at frame end");
    err_zero_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        !(fe_o || dor_o || pe_o))
        else $error("error flag set in master spi mode");
    udre_flag_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        tx_on && data_wr_i && udre_o |=> !udre_o || load)
        else $error("write did not fill transmit buffer");
    sck_idle_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        st_r == UMS_IDLE |-> sck_o == cpol_i)
        else $error("transfer clock idle level wrong");
    rx_only_en_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        !rx_en_i |=> !rxc_o)
        else $error("receive data held with receiver off");
    mosi_ovr_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        mosi_oe_o == (mspi_on && tx_en_i))
        else $error("serial out override wrong");
endmodule

// ===== test/ums_spi_slave.sv
/*
 * ums_spi_slave: behavioural spi slave on the serial pins of the master.
 * assumes the bench reloads its reply byte while the bus is idle and
 * keeps polarity, phase and order steady during frames.
 */
module ums_spi_slave (
    input  wire logic       sck_i,       // transfer clock from master
    input  wire logic       mosi_i,      // serial out of master
    input  wire logic       cpol_i,      // clock polarity bit
    input  wire logic       cpha_i,      // clock phase bit
    input  wire logic       lsb_first_i, // data order bit
    input  wire logic       load_i,      // restart with a new reply
    input  wire logic [7:0] reply_i,     // byte sent back each frame
    output logic            miso_o,      // serial in of master
    output logic [7:0]      got_o        // last byte shifted in
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [3:0] cnt_r;
    logic       out_r;
    logic [2:0] idx;

    // bit to present next, wrapping so frames follow back to back
    assign idx = lsb_first_i ? cnt_r[2:0] : 3'h7 - cnt_r[2:0];

    // sample on one edge, set up the next bit on the other
    always @(sck_i or posedge load_i) begin
        if (load_i) begin
            cnt_r = 4'h0;
            // idx lags cnt_r here, so pick the first bit directly
            out_r = lsb_first_i ? reply_i[0] : reply_i[7];
        end else if (sck_i ^ cpol_i ^ cpha_i) begin
            cnt_r = (cnt_r == 4'h8) ? 4'h1 : cnt_r + 4'h1;
            got_o = lsb_first_i ? {mosi_i, got_o[7:1]}
                                : {got_o[6:0], mosi_i};
        end else begin
            out_r = reply_i[idx];
        end
    end

    // output settles a little after the clock edge that moved it
    assign #1 miso_o = out_r;
endmodule

// ===== test/tb_top.sv
/*
 * tb_top: self-checking bench for the master spi transfer block.
 * assumes a slave model on the serial pins and plain control ports.
 */
`define CHK(g, e) chk(16'(g), 16'(e))
module tb_top import ums_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;

    logic                  clk_sys, arst_n, tx_en, rx_en, cpol, cpha, lsb;
    logic                  data_wr, data_rd, txc_clr, load;
    logic [1:0]            mode;
    logic [UMS_BAUD_W-1:0] baud;
    logic [7:0]            wdata, rdata, reply, got;
    logic                  rxc, txc, udre, fe, data_overrun_flag, pe, busy;
    logic                  sck, sck_oe, mosi, mosi_oe, miso, miso_ovr;
    logic [7:0]            pat [4] = '{8'h96, 8'h01, 8'h80, 8'h5A};
    int                    n_mismatch = 0;
    int                    comparisons = 0;

    ums_mspi u_ums_mspi (
        .clk_sys_i(clk_sys), .arst_n_i(arst_n), .mode_sel_i(mode),
        .tx_en_i(tx_en), .rx_en_i(rx_en), .cpol_i(cpol), .cpha_i(cpha),
        .lsb_first_i(lsb), .baud_div_i(baud), .data_wr_i(data_wr),
        .data_wdata_i(wdata), .data_rd_i(data_rd), .txc_clr_i(txc_clr),
        .data_rdata_o(rdata), .rxc_o(rxc), .txc_o(txc), .udre_o(udre),
        .fe_o(fe), .dor_o(data_overrun_flag), .pe_o(pe), .busy_o(busy), .sck_o(sck),
        .sck_oe_o(sck_oe), .mosi_o(mosi), .mosi_oe_o(mosi_oe),
        .miso_i(miso), .miso_ovr_o(miso_ovr));

    ums_spi_slave u_ums_spi_slave (
        .sck_i(sck), .mosi_i(mosi), .cpol_i(cpol), .cpha_i(cpha),
        .lsb_first_i(lsb), .load_i(load), .reply_i(reply),
        .miso_o(miso), .got_o(got));

    // free-running system clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // verdict and end of run
    task automatic complete_run();
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // compare with case equality, report at once
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // step to just after the next rising edge
    task automatic cyc();
        @(posedge clk_sys);
        #1;
    endtask

    // one-cycle data register write
    task automatic wr(input logic [7:0] b);
        data_wr = 1'b1;
        wdata = b;
        cyc();
        data_wr = 1'b0;
    endtask

    // check oldest byte then pop it
    task automatic rd(input logic [7:0] e);
        `CHK(rdata, e);
        data_rd = 1'b1;
        cyc();
        data_rd = 1'b0;
        cyc();
    endtask

    // bounded wait on the empty flag (1) or the complete flag (0)
    task automatic wait_on(input bit use_udre);
        for (int i = 0; i < 4000; i++) begin
            if ((use_udre ? udre : txc) === 1'b1) return;
            cyc();
        end
        n_mismatch++;
        complete_run();
    endtask

    // cycles until the transfer clock next changes
    task automatic edge_gap(output int n);
        logic prev;
        prev = sck;
        n = 0;
        while (sck === prev && n < 100) begin
            cyc();
            n++;
        end
    endtask

    // one full duplex byte in the given mode and rate
    task automatic xfer(input logic [7:0] tx, input logic [7:0] rep,
                        input logic [11:0] div, input logic p,
                        input logic h, input logic l);
        int n;
        cpol = p;
        cpha = h;
        lsb = l;
        cyc();
        baud = div;
        reply = rep;
        load = 1'b1;
        txc_clr = 1'b1;
        cyc();
        load = 1'b0;
        txc_clr = 1'b0;
        wait_on(1);
        wr(tx);
        edge_gap(n);
        edge_gap(n);
        `CHK(n, div + 12'h001);
        wait_on(0);
        `CHK(got, tx);
        cyc();
        `CHK(rxc, rx_en);
        if (rx_en) rd(rep);
    endtask

    // main sequence
    initial begin
        {arst_n, tx_en, rx_en, cpol, cpha, lsb} = 6'h00;
        {data_wr, data_rd, txc_clr, load, mode} = 6'h00;
        {baud, wdata, reply} = '0;
        repeat (6) @(posedge clk_sys);
        #1;
        arst_n = 1'b1;
        `CHK({txc, rxc, fe, data_overrun_flag, pe, mosi}, 6'h01);
        `CHK({sck_oe, mosi_oe, miso_ovr}, 3'h0);
        mode = UMS_MODE_MSPI;
        cyc();
        `CHK({sck_oe, mosi_oe, udre}, 3'h4);
        tx_en = 1'b1;
        rx_en = 1'b1;
        cyc();
        `CHK({mosi_oe, miso_ovr, udre}, 3'h7);
        for (int m = 0; m < 8; m++) begin
            xfer(pat[m % 4], ~pat[(m + 1) % 4], 12'(m % 3), m[1], m[0], m[2]);
        end
        // queue while shifting, write into full buffer, overflow
        xfer(8'hE7, 8'hC3, 12'h001, 1'b0, 1'b0, 1'b0);
        txc_clr = 1'b1;
        cyc();
        txc_clr = 1'b0;
        wr(8'h11);
        wait_on(1);
        wr(8'h22);
        `CHK({udre, busy}, 2'h1);
        cyc();
        wr(8'h33);
        wait_on(1);
        wr(8'h44);
        wait_on(0);
        `CHK(got, 8'h44);
        cyc();
        rd(8'hC3);
        rd(8'hC3);
        `CHK({rxc, fe, data_overrun_flag, pe}, 4'h0);
        txc_clr = 1'b1;
        cyc();
        txc_clr = 1'b0;
        `CHK(txc, 1'b0);
        // receiver off: transmit only
        rx_en = 1'b0;
        cyc();
        `CHK(miso_ovr, 1'b0);
        xfer(8'h6B, 8'hFF, 12'h000, 1'b1, 1'b1, 1'b0);
        // transmitter off, then wrong mode: nothing starts
        tx_en = 1'b0;
        cyc();
        `CHK({mosi_oe, udre}, 2'h0);
        wr(8'h77);
        repeat (4) cyc();
        `CHK(busy, 1'b0);
        mode = 2'h1;
        tx_en = 1'b1;
        cyc();
        `CHK({sck_oe, udre}, 2'h0);
        wr(8'h78);
        repeat (4) cyc();
        `CHK(busy, 1'b0);
        complete_run();
    end
endmodule
